// ===== hw/rfr_pkg.sv
// Constants, types and a helper function shared by the radio frame transfer block
package rfr_pkg;

  // ************************************************************
  // Framing and timing
  // ************************************************************
  localparam int          CLK_MHZ        = 40;
  localparam int          PREAMBLE_BYTES = 4;
  localparam logic [1:0]  PRE_LAST       = 2'(PREAMBLE_BYTES - 1);
  localparam logic [7:0]  PREAMBLE_VAL   = 8'h00;
  localparam logic [7:0]  SFD_VAL        = 8'ha7;
  localparam logic [7:0]  MAX_PAYLOAD    = 8'h7d;
  localparam logic [7:0]  FCS_BYTES      = 8'h02;
  localparam logic [7:0]  MAX_FRAME_LEN  = MAX_PAYLOAD + FCS_BYTES;
  localparam int          LQI_TIME_US    = 64;
  localparam logic [11:0] LQI_CYCLES     = 12'(LQI_TIME_US * CLK_MHZ);
  localparam int          CCA_TIME_US    = 128;
  localparam int          CCA_CYCLES     = CCA_TIME_US * CLK_MHZ;
  localparam logic [15:0] CRC_INIT       = 16'h0000;
  localparam logic [15:0] CRC_POLY_REV   = 16'h8408;

  // ************************************************************
  // Buffers and SPI commands
  // ************************************************************
  localparam int          TX_WORDS       = 63;
  localparam int          RX_WORDS       = 65;
  localparam logic [6:0]  LQI_WORD       = 7'h40;
  localparam logic [4:0]  SPI_CMD_LAST   = 5'h07;
  localparam logic [4:0]  SPI_WORD_FIRST = 5'h08;
  localparam logic [4:0]  SPI_WORD_LAST  = 5'h17;
  localparam logic [7:0]  CMD_TXBUF_WR   = 8'h01;
  localparam logic [7:0]  CMD_RXBUF_RD   = 8'h02;
  localparam logic [7:0]  CMD_STRM_WR    = 8'h03;
  localparam logic [7:0]  CMD_STRM_RD    = 8'h04;

  typedef enum logic [2:0] {
    TX_IDLE = 3'h0, TX_PRE = 3'h1, TX_SFD = 3'h2, TX_LEN = 3'h3, TX_PAY = 3'h4, TX_FCS = 3'h5
  } rfr_tx_state_t;

  typedef enum logic [2:0] {
    RX_HUNT = 3'h0, RX_SFD = 3'h1, RX_LEN = 3'h2, RX_PAY = 3'h3, RX_FCS = 3'h4
  } rfr_rx_state_t;

  typedef struct packed {
    logic rxDone;
    logic txDone;
    logic strmRx;
    logic strmTx;
  } rfr_irq_t;

  typedef struct packed {
    logic [7:0] data;
    logic       valid;
  } rfr_byte_t;

  typedef struct packed {
    logic       crcOk;
    logic [7:0] lqi;
  } rfr_rx_status_t;

  // Reflected CRC-16, bit 0 first, as sent on air
  function automatic logic [15:0] rfr_crc_step(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc;
    for (int i = 0; i < 8; i++)
    begin
      c = (c[0] ^ data[i]) ? ((c >> 1) ^ CRC_POLY_REV) : (c >> 1);
    end
    return c;
  endfunction : rfr_crc_step

endpackage : rfr_pkg

// ===== hw/rfr_frame_xfer.sv
// Frame transfer core: SPI slave, transmit framer, receive parser, link quality and CCA
`timescale 1ns/1ps
module rfr_frame_xfer
  import rfr_pkg::*;
#(
  parameter int unsigned CCA_CYCLES_P = CCA_CYCLES
)(
  input  wire logic           clk,
  input  wire logic           rst_n,
  input  wire logic           spiSclk,
  input  wire logic           spiCsN,
  input  wire logic           spiMosi,
  output logic                spiMisoOut,
  output logic                spiMisoOeN,
  output logic                irq,
  output rfr_irq_t            irqCause,
  input  wire logic           streamMode,
  input  wire logic           txReq,
  input  wire logic [6:0]     txPayLen,
  output logic [7:0]          txByte,
  output logic                txValid,
  input  wire logic           txReady,
  output logic                txBusy,
  input  wire logic           rxEnable,
  input  wire rfr_byte_t      rxIn,
  output rfr_rx_status_t      rxStatus,
  input  wire logic [7:0]     energy,
  input  wire logic           ccaReq,
  input  wire logic [23:0]    ccaLimit,
  output logic                ccaBusy,
  output logic                ccaDone
);

  // ************************************************************
  // Pin synchronisers: order is {sclk, csN, mosi}
  // ************************************************************
  logic [2:0] pinS1_ff, pinS2_ff, pinS3_ff, pinFilt_ff;
  wire  [2:0] pinDiff      = pinS2_ff ^ pinS3_ff;
  wire  [2:0] nxt_pinFilt  = (pinS2_ff & ~pinDiff) | (pinFilt_ff & pinDiff);
  wire        csFall       = pinFilt_ff[1] & ~nxt_pinFilt[1];
  wire        sclkRise     = ~pinFilt_ff[2] & nxt_pinFilt[2] & ~nxt_pinFilt[1];
  wire        sclkFall     = pinFilt_ff[2] & ~nxt_pinFilt[2] & ~nxt_pinFilt[1];
  wire        mosiBit      = nxt_pinFilt[0];

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pinS1_ff   <= 3'h2;
      pinS2_ff   <= 3'h2;
      pinS3_ff   <= 3'h2;
      pinFilt_ff <= 3'h2;
    end
    else
    begin
      pinS1_ff   <= {spiSclk, spiCsN, spiMosi};
      pinS2_ff   <= pinS1_ff;
      pinS3_ff   <= pinS2_ff;
      pinFilt_ff <= nxt_pinFilt;
    end
  end

  // ************************************************************
  // SPI slave: 8-bit command then 16-bit words, MSB first, mode 0
  // ************************************************************
  logic [4:0]  bitCnt_ff;
  logic [14:0] shIn_ff;
  logic [7:0]  cmd_ff;
  logic [6:0]  ptr_ff;
  logic [15:0] misoSh_ff;
  logic [15:0] txBuf [TX_WORDS];
  logic [15:0] rxBuf [RX_WORDS];
  logic [15:0] strmTxWord_ff, strmRxWord_ff;
  logic        strmTxFull_ff;

  wire        cmdDone   = sclkRise && (bitCnt_ff == SPI_CMD_LAST);
  wire        wordDone  = sclkRise && (bitCnt_ff == SPI_WORD_LAST);
  wire [15:0] wordIn    = {shIn_ff, mosiBit};
  wire        bufWr     = wordDone && (cmd_ff == CMD_TXBUF_WR) && (ptr_ff < 7'(TX_WORDS));
  wire        strmWr    = wordDone && (cmd_ff == CMD_STRM_WR);
  wire        rdLoad    = sclkFall && (bitCnt_ff == SPI_WORD_FIRST);
  wire        rxBufRd   = (cmd_ff == CMD_RXBUF_RD) && (ptr_ff < 7'(RX_WORDS));
  wire [15:0] rdWord    = rxBufRd ? rxBuf[ptr_ff] :
                          (cmd_ff == CMD_STRM_RD) ? strmRxWord_ff : 16'h0000;
  wire        ptrStep   = bufWr || (rdLoad && rxBufRd);

  always_ff @(posedge clk)
  begin
    if (!rst_n || csFall)
    begin
      bitCnt_ff <= 5'h00;
      shIn_ff   <= 15'h0000;
      cmd_ff    <= 8'h00;
      ptr_ff    <= 7'h00;
      misoSh_ff <= 16'h0000;
    end
    else
    begin
      if (sclkRise)
      begin
        shIn_ff   <= wordIn[14:0];
        bitCnt_ff <= wordDone ? SPI_WORD_FIRST : bitCnt_ff + 5'h01;
      end
      if (cmdDone)
        cmd_ff <= wordIn[7:0];
      if (ptrStep)
        ptr_ff <= ptr_ff + 7'h01;
      if (rdLoad)
        misoSh_ff <= rdWord;
      else if (sclkFall)
        misoSh_ff <= {misoSh_ff[14:0], 1'b0};
    end
  end

  assign spiMisoOut = misoSh_ff[15];
  assign spiMisoOeN = pinFilt_ff[1];

  // Host writes the whole payload first, then pulses txReq
  always_ff @(posedge clk)
  begin
    if (bufWr)
      txBuf[ptr_ff[5:0]] <= wordIn;
  end

  // ************************************************************
  // Transmit framer
  // ************************************************************
  rfr_tx_state_t txState_ff, nxt_txState;
  logic [6:0]    txCnt_ff, nxt_txCnt;
  logic [6:0]    txLen_ff;
  logic [15:0]   txCrc_ff;
  logic [7:0]    txByte_ff;
  logic          txRdy_ff;
  logic [7:0]    curByte;

  wire        txStart   = txReq && (txState_ff == TX_IDLE) && ({1'b0, txPayLen} <= MAX_PAYLOAD);
  wire        txAccept  = txRdy_ff && txReady;
  wire        lastPay   = (txCnt_ff == txLen_ff - 7'h01);
  wire [15:0] payWord   = streamMode ? strmTxWord_ff : txBuf[txCnt_ff[6:1]];
  wire [7:0]  payByte   = txCnt_ff[0] ? payWord[15:8] : payWord[7:0];
  wire        srcAvail  = !(streamMode && (txState_ff == TX_PAY)) || strmTxFull_ff;
  wire        txFetch   = (txState_ff != TX_IDLE) && !txRdy_ff && srcAvail;
  wire        txLast    = txAccept && (txState_ff == TX_FCS) && txCnt_ff[0];
  wire        strmUse   = txAccept && streamMode && (txState_ff == TX_PAY)
                          && (txCnt_ff[0] || lastPay);
  wire        strmNeed  = streamMode && !strmTxFull_ff && (txLen_ff != 7'h00)
                          && (txState_ff inside {TX_PRE, TX_SFD, TX_LEN, TX_PAY});

  always_comb
  begin
    unique case (txState_ff)
      TX_IDLE: curByte = PREAMBLE_VAL;
      TX_PRE:  curByte = PREAMBLE_VAL;
      TX_SFD:  curByte = SFD_VAL;
      TX_LEN:  curByte = {1'b0, txLen_ff} + FCS_BYTES;
      TX_PAY:  curByte = payByte;
      TX_FCS:  curByte = txCnt_ff[0] ? txCrc_ff[15:8] : txCrc_ff[7:0];
      default: curByte = PREAMBLE_VAL;
    endcase
  end

  always_comb
  begin
    nxt_txState = txState_ff;
    nxt_txCnt   = txCnt_ff;
    if (txStart)
    begin
      nxt_txState = TX_PRE;
      nxt_txCnt   = 7'h00;
    end
    else if (txAccept)
    begin
      nxt_txCnt = txCnt_ff + 7'h01;
      unique case (txState_ff)
        TX_PRE:
        begin
          if (txCnt_ff[1:0] == PRE_LAST)
            nxt_txState = TX_SFD;
        end
        TX_SFD: nxt_txState = TX_LEN;
        TX_LEN:
        begin
          nxt_txState = (txLen_ff == 7'h00) ? TX_FCS : TX_PAY;
          nxt_txCnt   = 7'h00;
        end
        TX_PAY:
        begin
          if (lastPay)
          begin
            nxt_txState = TX_FCS;
            nxt_txCnt   = 7'h00;
          end
        end
        TX_FCS:
        begin
          if (txCnt_ff[0])
            nxt_txState = TX_IDLE;
        end
        default: nxt_txState = TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      txState_ff    <= TX_IDLE;
      txCnt_ff      <= 7'h00;
      txLen_ff      <= 7'h00;
      txCrc_ff      <= CRC_INIT;
      txByte_ff     <= 8'h00;
      txRdy_ff      <= 1'b0;
      strmTxWord_ff <= 16'h0000;
      strmTxFull_ff <= 1'b0;
    end
    else
    begin
      txState_ff <= nxt_txState;
      txCnt_ff   <= nxt_txCnt;
      if (txStart)
      begin
        txLen_ff <= txPayLen;
        txCrc_ff <= CRC_INIT;
      end
      else if (txAccept && (txState_ff == TX_PAY))
        txCrc_ff <= rfr_crc_step(txCrc_ff, txByte_ff);
      if (txFetch)
        txByte_ff <= curByte;
      txRdy_ff <= txFetch || (txRdy_ff && !txReady);
      if (strmWr)
        strmTxWord_ff <= wordIn;
      strmTxFull_ff <= strmWr || (strmTxFull_ff && !strmUse);
    end
  end

  assign txByte  = txByte_ff;
  assign txValid = txRdy_ff;
  assign txBusy  = (txState_ff != TX_IDLE);

  // ************************************************************
  // Receive parser, buffer store and link quality
  // ************************************************************
  rfr_rx_state_t  rxState_ff;
  logic [6:0]     rxCnt_ff, rxLen_ff;
  logic [15:0]    rxCrc_ff;
  logic [7:0]     rxLow_ff, fcsLo_ff;
  rfr_rx_status_t rxStatus_ff;
  logic [11:0]    lqiCnt_ff;
  logic [19:0]    lqiAcc_ff;

  wire        rxEv      = rxIn.valid && rxEnable;
  wire [7:0]  rxData    = rxIn.data;
  wire        preDone   = rxEv && (rxState_ff == RX_HUNT) && (rxData == PREAMBLE_VAL)
                          && (rxCnt_ff[1:0] == PRE_LAST);
  wire        lenBad    = (rxData > MAX_FRAME_LEN) || (rxData < FCS_BYTES);
  wire        inBody    = (rxState_ff == RX_PAY) || (rxState_ff == RX_FCS);
  wire        rxLastB   = (rxCnt_ff == rxLen_ff - 7'h01);
  wire        rxLastPay = (rxCnt_ff == rxLen_ff - 7'h03);
  wire        rxWr      = rxEv && inBody && (rxCnt_ff[0] || rxLastB);
  wire [15:0] rxWrData  = rxCnt_ff[0] ? {rxData, rxLow_ff} : {8'h00, rxData};
  wire        rxEnd     = rxEv && (rxState_ff == RX_FCS) && rxLastB;
  wire        crcMatch  = ({rxData, fcsLo_ff} == rxCrc_ff);
  wire        lqiEnd    = (lqiCnt_ff == 12'h001);
  // The sample on the closing edge counts too, so the window holds a full 64 us
  wire [19:0] lqiSum    = lqiAcc_ff + {12'h000, energy};
  wire [7:0]  lqiVal    = lqiSum[19:12];

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rxState_ff  <= RX_HUNT;
      rxCnt_ff    <= 7'h00;
      rxLen_ff    <= 7'h00;
      rxCrc_ff    <= CRC_INIT;
      rxLow_ff    <= 8'h00;
      fcsLo_ff    <= 8'h00;
      rxStatus_ff <= '0;
    end
    else if (rxEv)
    begin
      rxCnt_ff <= rxCnt_ff + 7'h01;
      rxLow_ff <= rxData;
      unique case (rxState_ff)
        RX_HUNT:
        begin
          if (rxData != PREAMBLE_VAL)
            rxCnt_ff <= 7'h00;
          else if (preDone)
            rxState_ff <= RX_SFD;
        end
        RX_SFD:
        begin
          if (rxData == SFD_VAL)
            rxState_ff <= RX_LEN;
          else if (rxData != PREAMBLE_VAL)
            rxState_ff <= RX_HUNT;
          rxCnt_ff <= 7'h00;
        end
        RX_LEN:
        begin
          rxLen_ff   <= rxData[6:0];
          rxCrc_ff   <= CRC_INIT;
          rxCnt_ff   <= 7'h00;
          rxState_ff <= lenBad ? RX_HUNT : (rxData == FCS_BYTES) ? RX_FCS : RX_PAY;
        end
        RX_PAY:
        begin
          rxCrc_ff <= rfr_crc_step(rxCrc_ff, rxData);
          if (rxLastPay)
            rxState_ff <= RX_FCS;
        end
        RX_FCS:
        begin
          fcsLo_ff <= rxData;
          if (rxLastB)
          begin
            rxStatus_ff.crcOk <= crcMatch;
            rxState_ff        <= RX_HUNT;
            rxCnt_ff          <= 7'h00;
          end
        end
        default: rxState_ff <= RX_HUNT;
      endcase
    end
    if (rst_n && lqiEnd)
      rxStatus_ff.lqi <= lqiVal;
  end

  // Link quality window opens on the last preamble byte; frames are shorter than a retrigger
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      lqiCnt_ff <= 12'h000;
      lqiAcc_ff <= 20'h00000;
    end
    else if (preDone)
    begin
      lqiCnt_ff <= LQI_CYCLES;
      lqiAcc_ff <= 20'h00000;
    end
    else if (lqiCnt_ff != 12'h000)
    begin
      lqiCnt_ff <= lqiCnt_ff - 12'h001;
      lqiAcc_ff <= lqiSum;
    end
  end

  // Payload and check bytes packed low byte first; quality word sits after them
  always_ff @(posedge clk)
  begin
    if (rxWr)
      rxBuf[rxCnt_ff[6:1]] <= rxWrData;
    if (lqiEnd)
      rxBuf[LQI_WORD] <= {8'h00, lqiVal};
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      strmRxWord_ff <= 16'h0000;
    else if (rxWr && streamMode)
      strmRxWord_ff <= rxWrData;
  end

  assign rxStatus = rxStatus_ff;

  // ************************************************************
  // Channel-clear assessment
  // ************************************************************
  logic [15:0] ccaCnt_ff;
  logic [23:0] ccaAcc_ff;
  logic        ccaBusy_ff, ccaDone_ff;
  wire  [23:0] ccaSum   = ccaAcc_ff + {16'h0000, energy};
  wire         ccaStart = ccaReq && (ccaCnt_ff == 16'h0000);
  wire         ccaLast  = (ccaCnt_ff == 16'h0001);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ccaCnt_ff  <= 16'h0000;
      ccaAcc_ff  <= 24'h000000;
      ccaBusy_ff <= 1'b0;
      ccaDone_ff <= 1'b0;
    end
    else
    begin
      ccaDone_ff <= ccaLast;
      if (ccaStart)
      begin
        ccaCnt_ff <= 16'(CCA_CYCLES_P);
        ccaAcc_ff <= 24'h000000;
      end
      else if (ccaCnt_ff != 16'h0000)
      begin
        ccaCnt_ff <= ccaCnt_ff - 16'h0001;
        ccaAcc_ff <= ccaSum;
      end
      if (ccaLast)
        ccaBusy_ff <= (ccaSum >= ccaLimit);
    end
  end

  assign ccaBusy = ccaBusy_ff;
  assign ccaDone = ccaDone_ff;

  // ************************************************************
  // Interrupt causes: sticky, cleared by the next chip select, a new event wins
  // ************************************************************
  rfr_irq_t irqCause_ff, irqSet;
  assign irqSet.rxDone = rxEnd;
  assign irqSet.txDone = txLast;
  assign irqSet.strmRx = rxWr && streamMode;
  assign irqSet.strmTx = strmNeed;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      irqCause_ff <= '0;
    else
      irqCause_ff <= (csFall ? rfr_irq_t'('0) : irqCause_ff) | irqSet;
  end

  assign irqCause = irqCause_ff;
  assign irq      = |irqCause_ff;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  pre_byte_a: assert property (txValid && txState_ff == TX_PRE |-> txByte == PREAMBLE_VAL)
    else $error("preamble byte wrong");
  len_byte_a: assert property (txValid && txState_ff == TX_LEN |-> txByte == {1'b0, txLen_ff} + FCS_BYTES)
    else $error("length byte wrong");
  fcs_follows_a: assert property (txAccept && txState_ff == TX_PAY && lastPay |=> txState_ff == TX_FCS)
    else $error("check bytes do not follow payload");
  tx_done_irq_a: assert property (txLast |=> irqCause.txDone && irq && txState_ff == TX_IDLE)
    else $error("transmit done not signalled");
  rx_done_irq_a: assert property (rxEnd |=> irqCause.rxDone && rxStatus.crcOk == $past(crcMatch))
    else $error("receive done or check result wrong");
  rx_len_guard_a: assert property (rxEv && rxState_ff == RX_LEN && lenBad |=> rxState_ff == RX_HUNT)
    else $error("oversize frame accepted");
  tx_len_guard_a: assert property (txReq && {1'b0, txPayLen} > MAX_PAYLOAD && !txBusy |=> !txBusy)
    else $error("oversize send started");
  strm_tx_req_a: assert property (strmNeed |=> irqCause.strmTx)
    else $error("stream word request missing");
  strm_rx_word_a: assert property (rxWr && streamMode |=> irqCause.strmRx && strmRxWord_ff == $past(rxWrData))
    else $error("stream receive word lost");
  lqi_window_a: assert property (preDone |=> lqiCnt_ff == LQI_CYCLES ##(1) lqiCnt_ff == LQI_CYCLES - 12'h001)
    else $error("quality window wrong length");
  miso_load_a: assert property (rdLoad |=> spiMisoOut == $past(rdWord[15]))
    else $error("read word not presented on miso");

  tx_frame_c: cover property (txLast);
  rx_frame_c: cover property (rxEnd && crcMatch);
  strm_tx_c:  cover property (strmUse);
  cca_c:      cover property (ccaDone && ccaBusy);

endmodule : rfr_frame_xfer

// ===== verification/rfr_host_model.sv
// Host model: mode 0 SPI master beside the radio frame transfer block
`timescale 1ns/1ps
module rfr_host_model (
  output logic     spiSclk,
  output logic     spiCsN,
  output logic     spiMosi,
  input wire logic spiMisoOut,
  input wire logic spiMisoOeN
);
  logic        lastMiso = 1'b0;
  logic [15:0] wrQ[$];
  logic [15:0] rdQ[$];
  // A released line toggles, so a stale bit never passes for data
  wire         misoLine = spiMisoOeN ? ~lastMiso : spiMisoOut;

  initial
  begin
    spiSclk = 1'b0;
    spiCsN = 1'b1;
    spiMosi = 1'b0;
  end

  // Command byte then 16-bit words, MSB first; SCLK stands low outside frames
  task automatic xfer(input logic [7:0] cmd, input int n);
    logic [15:0] sh;
    sh = 16'h0000;
    // Only words shifted in by this transfer are handed back
    rdQ.delete();
    spiCsN = 1'b0;
    #200;
    for (int i = 0; i < 8 + 16 * n; i++)
    begin
      if (i >= 8 && (i - 8) % 16 == 0)
        sh = (wrQ.size() > 0) ? wrQ.pop_front() : 16'h0000;
      spiMosi = (i < 8) ? cmd[7 - i] : sh[15];
      #100 spiSclk = 1'b1;
      // Sampled late in the high phase: the block's output lags SCLK by a few clocks
      #95 lastMiso = misoLine;
      if (i >= 8)
        sh = {sh[14:0], lastMiso};
      #5 spiSclk = 1'b0;
      if (i >= 8 && (i - 8) % 16 == 15)
        rdQ.push_back(sh);
    end
    #200 spiCsN = 1'b1;
    #200;
  endtask : xfer
endmodule : rfr_host_model

// ===== verification/rfr_frame_xfer_test.sv
// Self-checking bench for the frame transfer core
`timescale 1ns/1ps
module rfr_frame_xfer_test
  import rfr_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, streamMode = 1'b0, txReq = 1'b0, txReady = 1'b0;
  logic rxEnable = 1'b0, ccaReq = 1'b0, irq, txValid, txBusy, ccaBusy, ccaDone;
  logic spiSclk, spiCsN, spiMosi, spiMisoOut, spiMisoOeN;
  logic [6:0] txPayLen = 7'h00;
  logic [7:0] txByte, energy = 8'h00;
  logic [23:0] ccaLimit = 24'h000000;
  rfr_byte_t rxIn = '0;
  rfr_irq_t irqCause;
  rfr_rx_status_t rxStatus;
  logic [7:0] expQ[$];
  int errorCnt = 0, testsRun = 0, seed = 23607;

  always #12.5 clk = ~clk;

  rfr_frame_xfer #(.CCA_CYCLES_P(8)) u_dut (.clk(clk), .rst_n(rst_n), .spiSclk(spiSclk),
    .spiCsN(spiCsN), .spiMosi(spiMosi), .spiMisoOut(spiMisoOut), .spiMisoOeN(spiMisoOeN),
    .irq(irq), .irqCause(irqCause), .streamMode(streamMode), .txReq(txReq),
    .txPayLen(txPayLen), .txByte(txByte), .txValid(txValid), .txReady(txReady),
    .txBusy(txBusy), .rxEnable(rxEnable), .rxIn(rxIn), .rxStatus(rxStatus), .energy(energy),
    .ccaReq(ccaReq), .ccaLimit(ccaLimit), .ccaBusy(ccaBusy), .ccaDone(ccaDone));
  rfr_host_model u_host (.spiSclk(spiSclk), .spiCsN(spiCsN), .spiMosi(spiMosi),
    .spiMisoOut(spiMisoOut), .spiMisoOeN(spiMisoOeN));

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    testsRun++;
    if (s !== e)
    begin
      errorCnt++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic finalReport;
    $display("checks %0d mismatches %0d", testsRun, errorCnt);
    if (errorCnt == 0 && testsRun > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finalReport

  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c = CRC_INIT;
    foreach (b[i])
      for (int k = 0; k < 8; k++)
        c = (c[0] ^ b[i][k]) ? ((c >> 1) ^ CRC_POLY_REV) : (c >> 1);
    return c;
  endfunction : crc16

  task automatic waitFor(input int k);
    int t = 0;
    while (irqCause[k] !== 1'b1 && t < 20000)
    begin
      @(negedge clk);
      t++;
    end
  endtask : waitFor

  // The modem side stalls at random
  always @(negedge clk)
    txReady <= 1'($random(seed));

  // Each accepted byte is checked against the oldest expected one
  always @(posedge clk)
    if (rst_n && txValid === 1'b1 && txReady)
      chk("txByte", (expQ.size() > 0) ? {8'h00, expQ.pop_front()} : 16'hffff,
          {8'h00, txByte});

  task automatic txFrame(input int len, input logic strm);
    logic [7:0] p[$];
    logic [15:0] c;
    streamMode = strm;
    for (int i = 0; i < len; i++)
      p.push_back(8'($random(seed)));
    c = crc16(p);
    expQ = '{PREAMBLE_VAL, PREAMBLE_VAL, PREAMBLE_VAL, PREAMBLE_VAL, SFD_VAL, 8'(len + 2)};
    expQ = {expQ, p, c[7:0], c[15:8]};
    for (int i = 0; i < len; i += 2)
      u_host.wrQ.push_back({(i + 1 < len) ? p[i + 1] : 8'h00, p[i]});
    if (!strm)
      u_host.xfer(CMD_TXBUF_WR, (len + 1) / 2);
    @(negedge clk);
    txReq = 1'b1;
    txPayLen = 7'(len);
    @(negedge clk);
    txReq = 1'b0;
    if (strm)
    begin
      waitFor(0);
      chk("strmTx", 16'h1, {15'h0, irqCause.strmTx});
      u_host.xfer(CMD_STRM_WR, 1);
    end
    waitFor(2);
    chk("txDone", 16'h1, {15'h0, irq & irqCause.txDone});
    chk("txLeft", 16'h0, 16'(expQ.size()));
    $display("test tx len %0d done", len);
  endtask : txFrame

  task automatic sendRx(input logic [7:0] f[$]);
    foreach (f[i])
    begin
      @(negedge clk);
      rxIn = '{data: f[i], valid: 1'b1};
      @(negedge clk);
      rxIn.valid = 1'b0;
    end
  endtask : sendRx

  task automatic rxFrame(input int len, input logic bad, input logic strm);
    logic [7:0] p[$];
    logic [7:0] f[$];
    logic [15:0] c;
    logic [7:0] e;
    streamMode = strm;
    rxEnable = 1'b1;
    e = 8'($random(seed));
    energy = e;
    for (int i = 0; i < len; i++)
      p.push_back(8'($random(seed)));
    c = crc16(p) ^ {15'h0000, bad};
    p = {p, c[7:0], c[15:8]};
    f = {PREAMBLE_VAL, PREAMBLE_VAL, PREAMBLE_VAL, PREAMBLE_VAL, SFD_VAL, 8'(len + 2), p};
    sendRx(f);
    repeat (2) @(negedge clk);
    chk("crcOk", {15'h0, !bad}, {15'h0, rxStatus.crcOk});
    if (strm)
    begin
      chk("strmRx", 16'h1, {15'h0, irqCause.strmRx});
      u_host.xfer(CMD_STRM_RD, 1);
      chk("strmWord", {p[len + 1], p[len]}, u_host.rdQ.pop_front());
    end
    else
    begin
      chk("rxDone", 16'h1, {15'h0, irqCause.rxDone});
      u_host.xfer(CMD_RXBUF_RD, (len + 3) / 2);
      for (int i = 0; i < len + 2; i += 2)
        chk("rxWord", {(i + 1 < len + 2) ? p[i + 1] : 8'h00, p[i]},
            u_host.rdQ.pop_front());
      chk("irqClr", 16'h0, {15'h0, irq});
    end
    // The quality window runs on well past a short frame; let it close first
    repeat (2600) @(negedge clk);
    chk("lqi", 16'((int'(e) * int'(LQI_CYCLES)) >> 12), {8'h00, rxStatus.lqi});
    $display("test rx len %0d done", len);
  endtask : rxFrame

  // ************************************************************
  // Main sequence and watchdog
  // ************************************************************
  initial
  begin
    logic [7:0] e;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    txFrame(2, 1'b1);
    txFrame(1, 1'b0);
    txFrame(125, 1'b0);
    txReq = 1'b1;
    txPayLen = 7'h7e;
    @(negedge clk);
    txReq = 1'b0;
    repeat (3) @(negedge clk);
    chk("txBusy", 16'h0, {15'h0, txBusy});
    rxFrame(3, 1'b0, 1'b0);
    rxFrame(6, 1'b1, 1'b0);
    sendRx('{PREAMBLE_VAL, PREAMBLE_VAL, PREAMBLE_VAL, PREAMBLE_VAL, SFD_VAL, 8'hff});
    $display("test rx bad length done");
    rxFrame(2, 1'b0, 1'b1);
    for (int k = 0; k < 2; k++)
    begin
      e = 8'(1 + ($random(seed) & 63));
      energy = e;
      ccaLimit = 24'(k ? 10 * e : 7 * e);
      ccaReq = 1'b1;
      @(negedge clk);
      ccaReq = 1'b0;
      for (int t = 0; t < 40 && ccaDone !== 1'b1; t++)
        @(negedge clk);
      chk("ccaDone", 16'h1, {15'h0, ccaDone});
      chk("ccaBusy", {15'h0, k == 0}, {15'h0, ccaBusy});
      $display("test cca %0d done", k);
    end
    finalReport();
  end

  initial
  begin
    #2000000;
    errorCnt++;
    finalReport();
  end
endmodule : rfr_frame_xfer_test
